//--- hw/itc_error_check.v
// The register addresses and the AHB-Lite slave port are this design's own decisions.
`include "itc_regs.vh"

module itc_error_check #(
  parameter CELL_BITS = 6,
  parameter NCELLS    = 64,
  parameter ADDR_W    = 17
) (
  input  wire              clk,        // system clock
  input  wire              resetn,     // async reset, active low
  // register bus, AHB-Lite slave
  input  wire              hsel,       // slave select
  input  wire [31:0]       haddr,      // byte address
  input  wire [1:0]        htrans,     // transfer type
  input  wire              hwrite,     // write access
  input  wire [2:0]        hsize,      // transfer size
  input  wire [31:0]       hwdata,     // write data
  input  wire              hready,     // bus ready in
  output reg               hreadyout,  // slave ready
  output reg               hresp,      // always okay
  output reg  [31:0]       hrdata,     // read data
  // cell access stream from the array front end
  input  wire              accValid,   // one access this cycle
  input  wire              accWrite,   // store
  input  wire [2:0]        accSize,    // transfer size code
  input  wire [7:0]        accLen,     // beats minus one
  input  wire [ADDR_W-1:0] accAddr,    // physical address
  input  wire [63:0]       accData,    // store data
  input  wire [7:0]        accPar,     // store parity per byte
  input  wire [NCELLS-1:0] cellEmpty,  // empty flag per cell
  input  wire [NCELLS-1:0] cellFull,   // full flag per cell
  input  wire [NCELLS-1:0] cellFifo,   // cell is multi-element
  output reg               rspValid,   // answer to the access
  output reg               rspErr,     // error response
  output reg  [2:0]        rspKind,    // error kinds raised
  output reg  [CELL_BITS-1:0] rspCell, // decoded cell index
  // configuration toward the array
  output reg  [3:0]        cfgShift,   // index shift setting
  output reg  [6:0]        cfgCellNum, // configured cell count
  output reg               irq         // level interrupt
);

  // ****************************************************************
  // register state
  // ****************************************************************
  reg [`ITC_ERR_W-1:0]   errFlags_reg;
  reg [`ITC_ERR_W-1:0]   errFlags_next;
  reg [`ITC_ERR_W-1:0]   mask_reg;
  reg [3:0]              shift_reg;
  reg [6:0]              cellNum_reg;
  reg [CELL_BITS-1:0]    lastCell_reg;
  reg [3:0]              lastView_reg;

  reg                    wrPend_reg;
  reg [7:0]              wrOfs_reg;
  reg                    rdPend_reg;
  reg [7:0]              rdOfs_reg;

  // ****************************************************************
  // access decode
  // ****************************************************************
  wire                   parErr;
  reg  [CELL_BITS-1:0]   cellIdx;
  reg  [CELL_BITS-1:0]   spanMask;
  reg  [ADDR_W-1:0]      shifted;
  reg  [3:0]             view;
  reg                    cellE;
  reg                    cellF;
  reg                    cellQ;
  reg                    badCell;
  reg                    badSize;
  reg                    badExec;
  reg                    isEf;
  reg                    isPv;
  reg  [`ITC_ERR_W-1:0]  errSet;
  wire [CELL_BITS-1:0]   spanBits;

  itc_parity_chk #(
    .BYTES (8)
  ) u_par (
    .data (accData),
    .par  (accPar),
    .err  (parErr)
  );

  // ****************************************************************
  // span mask, one bit per index bit
  // ****************************************************************
  genvar k;
  generate
    for (k = 0; k < CELL_BITS; k = k + 1) begin : g_span
      // bit k is needed while two to the k is below the count
      assign spanBits[k] = ((8'h01 << k) < {1'b0, cellNum_reg});
    end
  endgenerate

  always @* begin
    // span mask is one below the smallest power of two covering the count
    spanMask = spanBits;
    shifted = accAddr >> (`ITC_INDEX_BASE + shift_reg);
    cellIdx = shifted[CELL_BITS-1:0] & spanMask;
    view    = accAddr[`ITC_VIEW_LSB +: `ITC_VIEW_W];
    badCell = ({1'b0, cellIdx} >= cellNum_reg);
    cellE   = cellEmpty[cellIdx];
    cellF   = cellFull[cellIdx];
    cellQ   = cellFifo[cellIdx];
    isEf    = (view == `ITC_VIEW_EF_SYNC) || (view == `ITC_VIEW_EF_TRY);
    isPv    = (view == `ITC_VIEW_PV_SYNC) || (view == `ITC_VIEW_PV_TRY);
  end

  // ****************************************************************
  // error terms, one per rule
  // ****************************************************************
  wire sizeBad       = (accSize != `ITC_SIZE_32) && (accSize != `ITC_SIZE_64);
  wire burstBad      = (accLen != 8'h00);
  wire ctrlMisplaced = (view == `ITC_VIEW_CTRL) && (cellIdx != {CELL_BITS{1'b0}});
  wire execEfSingle  = ~cellQ & isEf & (cellE == cellF);
  wire execPvSingle  = ~cellQ & isPv & (cellE | cellF);
  wire execEfFifo    = cellQ & isEf & cellE & cellF;
  wire execPvFifo    = cellQ & isPv;

  always @* begin
    // only 32 and 64 bit single beats are legal
    badSize = sizeBad | burstBad;
    badExec = 1'b0;
    if (badCell) begin
      badExec = 1'b1;
    end else if (ctrlMisplaced) begin
      badExec = 1'b1;
    end else if (execEfSingle) begin
      badExec = 1'b1;
    end else if (execPvSingle) begin
      badExec = 1'b1;
    end else if (execEfFifo) begin
      badExec = 1'b1;
    end else if (execPvFifo) begin
      badExec = 1'b1;
    end
    errSet = {`ITC_ERR_W{1'b0}};
    if (accValid) begin
      errSet[`ITC_ERR_BUS]  = badSize;
      errSet[`ITC_ERR_PAR]  = accWrite & parErr;
      errSet[`ITC_ERR_EXEC] = badExec;
    end
  end

  // ****************************************************************
  // access response
  // ****************************************************************
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rspValid     <= 1'b0;
      rspErr       <= 1'b0;
      rspKind      <= 3'h0;
      rspCell      <= {CELL_BITS{1'b0}};
    end else begin
      rspValid <= accValid;
      rspErr   <= |errSet;
      rspKind  <= errSet;
      rspCell  <= accValid ? cellIdx : rspCell;
    end
  end

  // ****************************************************************
  // last error capture
  // ****************************************************************
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lastCell_reg <= {CELL_BITS{1'b0}};
      lastView_reg <= 4'h0;
    end else begin
      if (|errSet) begin
        lastCell_reg <= cellIdx;
        lastView_reg <= view;
      end
    end
  end

  // ****************************************************************
  // register bus, address phase capture
  // ****************************************************************
  wire busTake = hsel & hready & htrans[1];

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPend_reg <= 1'b0;
      wrOfs_reg  <= 8'h00;
      rdPend_reg <= 1'b0;
      rdOfs_reg  <= 8'h00;
    end else begin
      // writes complete in their data phase, reads add one wait
      wrPend_reg <= busTake & hwrite;
      rdPend_reg <= busTake & ~hwrite;
      if (busTake) begin
        wrOfs_reg <= haddr[7:0];
        rdOfs_reg <= haddr[7:0];
      end
    end
  end

  // ****************************************************************
  // register bus, data phase and read mux
  // ****************************************************************
  reg [31:0] readMux;

  always @* begin
    case (rdOfs_reg)
      `ITC_OFS_CTRL: begin
        readMux = {29'h0, errFlags_reg};
      end
      `ITC_OFS_MASK: begin
        readMux = {29'h0, mask_reg};
      end
      `ITC_OFS_CFG: begin
        readMux = {17'h0, cellNum_reg, 4'h0, shift_reg};
      end
      `ITC_OFS_INFO: begin
        readMux = {{(28-CELL_BITS){1'b0}}, lastCell_reg, lastView_reg};
      end
      default: begin
        readMux = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      hresp <= 1'b0;
      if (busTake && !hwrite) begin
        hreadyout <= 1'b0;
      end else if (rdPend_reg && !hreadyout) begin
        hreadyout <= 1'b1;
        hrdata    <= readMux;
      end
    end
  end

  // ****************************************************************
  // control, mask and configuration registers
  // ****************************************************************
  wire wrCtrl = wrPend_reg & (wrOfs_reg == `ITC_OFS_CTRL);
  wire wrMask = wrPend_reg & (wrOfs_reg == `ITC_OFS_MASK);
  wire wrCfg  = wrPend_reg & (wrOfs_reg == `ITC_OFS_CFG);

  always @* begin
    errFlags_next = errFlags_reg;
    if (wrCtrl) begin
      errFlags_next = errFlags_next & ~hwdata[`ITC_ERR_W-1:0];
    end
    // a new error wins over a clear in the same cycle
    errFlags_next = errFlags_next | errSet;
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      errFlags_reg <= `ITC_ERR_RST;
      mask_reg     <= `ITC_MASK_RST;
      shift_reg    <= `ITC_SHIFT_RST;
      cellNum_reg  <= `ITC_CNUM_RST;
      cfgShift     <= `ITC_SHIFT_RST;
      cfgCellNum   <= `ITC_CNUM_RST;
      irq          <= 1'b0;
    end else begin
      errFlags_reg <= errFlags_next;
      if (wrMask) begin
        mask_reg <= hwdata[`ITC_ERR_W-1:0];
      end
      if (wrCfg) begin
        shift_reg   <= hwdata[`ITC_SHIFT_LSB +: `ITC_SHIFT_W];
        cellNum_reg <= hwdata[`ITC_CNUM_LSB +: `ITC_CNUM_W];
        cfgShift    <= hwdata[`ITC_SHIFT_LSB +: `ITC_SHIFT_W];
        cfgCellNum  <= hwdata[`ITC_CNUM_LSB +: `ITC_CNUM_W];
      end
      irq <= |(errFlags_next & mask_reg);
    end
  end

endmodule

//--- shared/itc_regs.vh
`ifndef ITC_REGS_VH
`define ITC_REGS_VH

// ****************************************************************
// register offsets (byte addresses on the register bus)
// ****************************************************************
`define ITC_OFS_CTRL      8'h00
`define ITC_OFS_MASK      8'h04
`define ITC_OFS_CFG       8'h08
`define ITC_OFS_INFO      8'h0c

// ****************************************************************
// control register error flags (sticky, write one to clear)
// ****************************************************************
`define ITC_ERR_BUS       0
`define ITC_ERR_PAR       1
`define ITC_ERR_EXEC      2
`define ITC_ERR_W         3
`define ITC_ERR_RST       3'h0
`define ITC_MASK_RST      3'h0

// ****************************************************************
// configuration register fields
// ****************************************************************
`define ITC_SHIFT_LSB     0
`define ITC_SHIFT_W       4
`define ITC_CNUM_LSB      8
`define ITC_CNUM_W        7
`define ITC_SHIFT_RST     4'h0
`define ITC_CNUM_RST      7'h20

// ****************************************************************
// access decode
// ****************************************************************
`define ITC_SIZE_32       3'h2
`define ITC_SIZE_64       3'h3
`define ITC_INDEX_BASE    7
`define ITC_VIEW_LSB      3
`define ITC_VIEW_W        4
`define ITC_VIEW_EF_SYNC  4'h2
`define ITC_VIEW_EF_TRY   4'h3
`define ITC_VIEW_PV_SYNC  4'h4
`define ITC_VIEW_PV_TRY   4'h5
`define ITC_VIEW_CTRL     4'hf

`endif

//--- hw/itc_parity_chk.v
// ****************************************************************
// even parity check, one parity bit per data byte
// ****************************************************************
module itc_parity_chk #(
  parameter BYTES = 8
) (
  input  wire [8*BYTES-1:0] data,   // write data
  input  wire [BYTES-1:0]   par,    // parity bit per byte
  output wire               err     // any byte fails even parity
);

  wire [BYTES-1:0] byteBad;

  genvar b;
  generate
    for (b = 0; b < BYTES; b = b + 1) begin : g_byte
      // byte plus its parity bit must hold an even count of ones
      assign byteBad[b] = ^{data[8*b+7:8*b], par[b]};
    end
  endgenerate

  assign err = |byteBad;

endmodule

//--- bench/itc_error_check_asserts.sv
// ******
// access port checks
// ******
module itc_error_check_asserts #(
  parameter CELL_BITS = 6,
  parameter ADDR_W    = 17
) (
  input logic                 clk,        // clock
  input logic                 resetn,     // reset
  input logic                 accValid,   // access
  input logic                 accWrite,   // store
  input logic [2:0]           accSize,    // size
  input logic [7:0]           accLen,     // beats-1
  input logic [ADDR_W-1:0]    accAddr,    // address
  input logic                 rspValid,   // answer
  input logic                 rspErr,     // error
  input logic [2:0]           rspKind,    // kinds
  input logic [CELL_BITS-1:0] rspCell,    // cell
  input logic [3:0]           cfgShift,   // shift
  input logic [6:0]           cfgCellNum  // count
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0]        span;
  logic [6:0]        idx;
  logic [ADDR_W-1:0] sh;

  // span: next power of two at or above the count, minus one
  always_comb begin
    span = cfgCellNum - 7'h01;
    span = span | (span >> 1);
    span = span | (span >> 2);
    span = span | (span >> 4);
    sh = accAddr >> (7 + cfgShift);
    idx = sh[6:0] & span;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_answer_next: assert property (accValid |=> rspValid)
    else $error("access not answered");
  a_size_fault: assert property (
    accValid && !(accSize inside {3'h2, 3'h3}) |=> rspKind[0]) else $error("size fault missed");
  a_burst_fault: assert property (accValid && accLen != 8'h00 |=> rspKind[0])
    else $error("burst fault missed");
  a_clean_bus: assert property (
    accValid && accSize inside {3'h2, 3'h3} && accLen == 8'h00 |=> !rspKind[0])
    else $error("false bus fault");
  a_read_nopar: assert property (accValid && !accWrite |=> !rspKind[1])
    else $error("parity fault on load");
  a_bad_cell: assert property (accValid && idx >= cfgCellNum |=> rspErr && rspKind[2])
    else $error("invalid cell passed");
  a_ctrl_view: assert property (
    accValid && accAddr[6:3] == 4'hf && idx != 7'h00 |=> rspErr && rspKind[2])
    else $error("misplaced control view passed");
  a_cell_decode: assert property (accValid |=> rspCell == $past(idx[CELL_BITS-1:0]))
    else $error("cell index wrong");
endmodule

bind itc_error_check itc_error_check_asserts #(.CELL_BITS(CELL_BITS), .ADDR_W(ADDR_W)) chk (.*);

//--- bench/itc_lsu_model.sv
// ******
// load/store master on the access port
// ******
module itc_lsu_model (
  output logic        accValid, // strobe
  output logic        accWrite, // store
  output logic [2:0]  accSize,  // size
  output logic [7:0]  accLen,   // beats-1
  output logic [16:0] accAddr,  // address
  output logic [63:0] accData,  // data
  output logic [7:0]  accPar    // parity
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {accValid, accWrite, accSize, accLen, accAddr, accData, accPar} = '0;
  // called just after a rising edge; v low releases the port and turns stale lines over
  task automatic issue(input logic v, w, input logic [2:0] s, input logic [7:0] n,
                       input logic [16:0] a, input logic [63:0] d, input logic [7:0] p);
    accValid <= v;
    accWrite <= w;
    accSize  <= s;
    accLen   <= n;
    accAddr  <= v ? {a[16:3], 3'h0} : ~accAddr;
    accData  <= v ? d : ~accData;
    accPar   <= p;
  endtask
endmodule

//--- bench/tb.sv
`include "itc_regs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, resetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp, irq;
  logic        accValid, accWrite, rspValid, rspErr, bus, par, xe, e, f, q;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 0, accSize, rspKind, s, fl = 0;
  logic [3:0]  cfgShift, shf = 0, vw;
  logic [5:0]  rspCell;
  logic [6:0]  cfgCellNum, cn = 7'h20, span, idx;
  logic [7:0]  accLen, accPar, p, n;
  logic [16:0] accAddr, a;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, r;
  logic [63:0] accData, d, cellEmpty = 0, cellFull = 0, cellFifo = 0;
  logic [191:0] st;
  logic [8:0]  pend[$], ex;
  integer      seed = 75, badCount = 0, nChecks = 0;
  logic [31:0] regAdr[5] = '{`ITC_OFS_CTRL, `ITC_OFS_MASK, `ITC_OFS_CFG, `ITC_OFS_INFO, 8'h10};
  logic [31:0] regRst[5] = '{32'h0, 32'h0, 32'h2000, 32'h0, 32'h0};
  assign hready = hreadyout;
  itc_error_check itc_error_check_inst (.*);
  itc_lsu_model itc_lsu_model_inst (.*);
  always #5 clk = ~clk;

  task automatic check(input logic [31:0] seen, exp);
    nChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ******
  // single AHB-Lite word transfer, waits on hready in both phases
  // ******
  task automatic ahb(input logic w, input logic [31:0] ad, wd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= ad;
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task conclude;
    if (badCount == 0 && nChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(negedge clk) begin
    if (resetn && rspValid === 1'b1) begin
      ex = pend.pop_front();
      check(rspKind, ex[2:0]);
      check(rspCell, ex[8:3]);
      check(rspErr, |ex[2:0]);
      fl = fl | ex[2:0];
    end
  end

  initial begin
    #50000;
    badCount++;
    conclude;
  end

  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    ahb(1'b1, `ITC_OFS_INFO, 32'hffffffff);
    for (int i = 0; i < 5; i++) begin
      ahb(1'b0, regAdr[i], 32'h0);
      check(rd, regRst[i]);
      check(hresp, 1'b0);
    end
    for (int ps = 0; ps < 2; ps++) begin
      if (ps == 1) begin
        shf = 4'h4;
        cn = 7'h14;
        ahb(1'b1, `ITC_OFS_CFG, {17'h0, cn, 4'h0, shf});
        repeat (2) @(posedge clk);
        check({cfgCellNum, cfgShift}, {cn, shf});
      end
      for (int i = 0; i < 80; i++) begin
        r = $random(seed);
        d = {$random(seed), $random(seed)};
        st = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed),
              $random(seed)};
        s = (r[3:0] < 4'hc) ? {2'b01, r[4]} : r[7:5];
        n = (r[11:8] == 4'h0) ? 8'h01 : 8'h00;
        vw = (r[14:12] > 3'h4) ? 4'hf : {1'b0, r[14:12] + 3'h1};
        a = ({12'h0, r[20:16]} << (7 + shf)) | {6'h0, r[24:21] & {4{shf != 0}}, vw, 3'h0};
        par = 1'b0;
        for (int b = 0; b < 8; b++) begin
          p[b] = ^d[8*b+:8] ^ (r[27:24] == 4'h0 && b == r[30:28]);
          par = par | (r[15] & ^{d[8*b+:8], p[b]});
        end
        span = 7'h00;
        while (span + 7'h01 < cn) span = {span[5:0], 1'b1};
        idx = 7'(a >> (7 + shf)) & span;
        e = st[128 + idx];
        f = st[64 + idx];
        q = st[idx];
        bus = !(s inside {3'h2, 3'h3}) || n != 8'h00;
        xe = idx >= cn || (vw == `ITC_VIEW_CTRL && idx != 7'h0)
             || (vw inside {`ITC_VIEW_EF_SYNC, `ITC_VIEW_EF_TRY} && (q ? e && f : e == f))
             || (vw inside {`ITC_VIEW_PV_SYNC, `ITC_VIEW_PV_TRY} && (q || e || f));
        @(posedge clk);
        {cellEmpty, cellFull, cellFifo} <= st;
        itc_lsu_model_inst.issue(1'b1, r[15], s, n, a, d, p);
        pend.push_back({idx[5:0], xe, par, bus});
      end
      @(posedge clk);
      itc_lsu_model_inst.issue(1'b0, 1'b0, 3'h0, 8'h0, 17'h0, 64'h0, 8'h0);
      repeat (3) @(posedge clk);
      ahb(1'b0, `ITC_OFS_CTRL, 32'h0);
      check(rd, {29'h0, fl});
      check(irq, 1'b0);
      ahb(1'b1, `ITC_OFS_CTRL, 32'h1);
      fl[0] = 1'b0;
      ahb(1'b1, `ITC_OFS_MASK, 32'h6);
      ahb(1'b0, `ITC_OFS_CTRL, 32'h0);
      check(rd, {29'h0, fl});
      check(irq, |fl[2:1]);
      ahb(1'b1, `ITC_OFS_CTRL, 32'h7);
      fl = 3'h0;
      repeat (2) @(posedge clk);
      check(irq, 1'b0);
      ahb(1'b1, `ITC_OFS_MASK, 32'h0);
    end
    conclude;
  end
endmodule
